// [verilog/chip_boot_pkg.sv]
// chip boot and program control: constants and types
// assumes one core clock and an ahb-lite register bus
package chip_boot_pkg;
   localparam logic [7:0] CHIP_CONTROL_OFFSET = 8'hBF;
   localparam int         BIT_REBOOT          = 7;
   localparam int         BIT_AUX_RAM         = 4;
   localparam int         BIT_ZERO_HI         = 3;
   localparam int         BIT_ZERO_LO         = 2;
   localparam int         BIT_LOADER_SEL      = 1;
   localparam int         BIT_PROG_EN         = 0;
   localparam logic [7:0] CHIP_CONTROL_RESET  = 8'h00;
   localparam int         REBOOT_PULSE_CYCLES = 4;
   localparam logic [1:0] HTRANS_NONSEQ       = 2'h2;
   localparam logic [2:0] HSIZE_WORD          = 3'h2;

   typedef struct packed {
      logic aux_ram_enable;
      logic loader_location_select;
      logic flash_program_enable;
   } ctrl_bits_t;

   typedef enum logic [1:0] {RUN, IDLE_WAIT, PROGRAMMING} mode_state_t;
endpackage

// [verilog/chip_boot_program_control.sv]
// chip control register, reboot and flash programming mode control
// assumes ahb-lite single word transfers and synchronous core-side idle/wake pulses
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
module chip_boot_program_control
   import chip_boot_pkg::*;
(
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   // ahb-lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   // core status
   input  wire logic        i_idle_entered,
   input  wire logic        i_irq_wake,
   input  wire logic        i_small_boot_mode,
   // chip controls
   output logic             o_chip_reset,
   output logic             o_aux_ram_enable,
   output logic             o_fetch_from_loader,
   output logic             o_loader_in_small_area,
   output logic             o_flash_write_allowed,
   output logic             o_programming_mode
);
   ctrl_bits_t   ctrl;
   mode_state_t  mode;
   mode_state_t  next_mode;
   logic         wr_pend;
   logic [2:0]   rst_cnt;
   logic [7:0]   rd_byte;

   // programming mode decode, used by several outputs
   function automatic logic is_prog(input mode_state_t m);
      is_prog = m == PROGRAMMING;
   endfunction

   // refuse a pulse length below 2 or above the 7 that the 3-bit counter can hold
   if (REBOOT_PULSE_CYCLES < 2 || REBOOT_PULSE_CYCLES > 7) begin : g_pulse_check
      $error("reboot pulse length out of range");
   end

   wire          addr_hit  = i_haddr[9:2] == CHIP_CONTROL_OFFSET;
   wire          take      = i_hsel & i_hready & (i_htrans == HTRANS_NONSEQ) & (i_hsize == HSIZE_WORD);
   wire          rd_hit    = take & ~i_hwrite & addr_hit;
   wire          wr_hit    = take & i_hwrite & addr_hit;
   wire          wr_now    = wr_pend;
   wire [7:0]    wbyte     = i_hwdata[7:0];
   wire          reboot_go = wr_now & wbyte[BIT_REBOOT] & ctrl.loader_location_select
                             & ctrl.flash_program_enable;
   assign rd_byte = {i_small_boot_mode, 2'h0, ctrl.aux_ram_enable, 2'h0,
                     ctrl.loader_location_select, ctrl.flash_program_enable};

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         wr_pend  <= 1'b0;
         o_hrdata <= 32'h0;
      end else begin
         wr_pend  <= wr_hit;
         o_hrdata <= rd_hit ? {24'h0, rd_byte} : 32'h0;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst | (rst_cnt != 3'h0)) begin
         ctrl <= {CHIP_CONTROL_RESET[BIT_AUX_RAM], CHIP_CONTROL_RESET[BIT_LOADER_SEL],
                  CHIP_CONTROL_RESET[BIT_PROG_EN]};
      end else if (wr_now) begin
         ctrl.aux_ram_enable         <= wbyte[BIT_AUX_RAM];
         ctrl.loader_location_select <= wbyte[BIT_LOADER_SEL];
         ctrl.flash_program_enable   <= wbyte[BIT_PROG_EN];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         rst_cnt <= 3'h0;
      end else if (reboot_go) begin
         rst_cnt <= 3'(REBOOT_PULSE_CYCLES);
      end else if (rst_cnt != 3'h0) begin
         rst_cnt <= rst_cnt - 3'h1;
      end
   end

   always_comb begin
      next_mode = mode;
      case (mode)
         RUN: begin
            if (ctrl.flash_program_enable & i_idle_entered) begin
               next_mode = IDLE_WAIT;
            end
         end
         IDLE_WAIT: begin
            if (!ctrl.flash_program_enable) begin
               next_mode = RUN;
            end else if (i_irq_wake) begin
               next_mode = PROGRAMMING;
            end
         end
         PROGRAMMING: begin
            if (!ctrl.flash_program_enable) begin
               next_mode = RUN;
            end
         end
         default: next_mode = RUN;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_rst | (rst_cnt != 3'h0)) begin
         mode <= RUN;
      end else begin
         mode <= next_mode;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_hreadyout            <= 1'b1;
         o_hresp                <= 1'b0;
         o_chip_reset           <= 1'b0;
         o_aux_ram_enable       <= 1'b0;
         o_fetch_from_loader    <= 1'b0;
         o_loader_in_small_area <= 1'b0;
         o_flash_write_allowed  <= 1'b0;
         o_programming_mode     <= 1'b0;
      end else begin
         o_hreadyout            <= 1'b1;
         o_hresp                <= 1'b0;
         o_chip_reset           <= reboot_go | (rst_cnt > 3'h1);
         o_aux_ram_enable       <= ctrl.aux_ram_enable;
         o_loader_in_small_area <= ctrl.loader_location_select;
         o_fetch_from_loader    <= is_prog(next_mode);
         o_programming_mode     <= is_prog(next_mode);
         o_flash_write_allowed  <= ctrl.flash_program_enable & is_prog(next_mode);
      end
   end

   // mode entry steps
   sequence seq_idle_seen;
      ctrl.flash_program_enable & i_idle_entered & (mode == RUN) & (rst_cnt == 3'h0);
   endsequence

   sequence seq_wake_seen;
      ctrl.flash_program_enable & i_irq_wake & (mode == IDLE_WAIT) & (rst_cnt == 3'h0);
   endsequence

   // reboot steps
   sequence seq_reboot_start;
      reboot_go ##1 (rst_cnt != 3'h0);
   endsequence

   sequence seq_reboot_alone;
      reboot_go ##1 (!reboot_go) [*4];
   endsequence

   AST_REBOOT_PULSE: assert property (@(posedge i_clock) disable iff (i_rst)
      reboot_go |=> o_chip_reset [*4]) else $error("reboot pulse too short");

   AST_REBOOT_CLEARS: assert property (@(posedge i_clock) disable iff (i_rst)
      seq_reboot_start |=> (!ctrl.aux_ram_enable & !ctrl.loader_location_select & (mode == RUN)))
      else $error("reboot did not clear state");

   AST_REBOOT_END: assert property (@(posedge i_clock) disable iff (i_rst)
      seq_reboot_alone |=> !o_chip_reset)
      else $error("reboot pulse too long");

   AST_IDLE_WAITS: assert property (@(posedge i_clock) disable iff (i_rst)
      seq_idle_seen |=> (mode == IDLE_WAIT))
      else $error("idle not followed");

   AST_WAKE_ENTERS: assert property (@(posedge i_clock) disable iff (i_rst)
      seq_wake_seen |=> (o_programming_mode & o_fetch_from_loader))
      else $error("wake did not enter programming");

   AST_NO_DIRECT_ENTRY: assert property (@(posedge i_clock) disable iff (i_rst)
      (mode == RUN) |=> (mode != PROGRAMMING))
      else $error("programming without idle");

   AST_DISABLED_RUN: assert property (@(posedge i_clock) disable iff (i_rst)
      !ctrl.flash_program_enable |=> !o_programming_mode)
      else $error("programming while disabled");

   AST_PROG_EXIT: assert property (@(posedge i_clock) disable iff (i_rst)
      (!ctrl.flash_program_enable & (mode == PROGRAMMING)) |=> (mode == RUN))
      else $error("programming not left");

   AST_NO_REBOOT_COUNT: assert property (@(posedge i_clock) disable iff (i_rst)
      (wr_now & ~reboot_go & (rst_cnt == 3'h0)) |=> (rst_cnt == 3'h0))
      else $error("reboot counter started");

   AST_SMALL_AREA: assert property (@(posedge i_clock) disable iff (i_rst)
      (wr_now & (rst_cnt == 3'h0)) |=> ##1 o_loader_in_small_area == $past(wbyte[BIT_LOADER_SEL], 2))
      else $error("loader area wrong");

   AST_READ_IDLE: assert property (@(posedge i_clock) disable iff (i_rst)
      !rd_hit |=> (o_hrdata == 32'h0))
      else $error("read data outside data phase");

   AST_NO_REBOOT: assert property (@(posedge i_clock) disable iff (i_rst)
      (wr_now & ~reboot_go & rst_cnt == 3'h0) |=> ##1 !o_chip_reset)
      else $error("spurious reboot");
   AST_AUX_FOLLOWS: assert property (@(posedge i_clock) disable iff (i_rst)
      (wr_now & rst_cnt == 3'h0) |=> ##1 o_aux_ram_enable == $past(wbyte[BIT_AUX_RAM], 2))
      else $error("aux ram enable wrong");
   AST_LOADER_SEL: assert property (@(posedge i_clock) disable iff (i_rst)
      o_loader_in_small_area == $past(ctrl.loader_location_select)) else $error("loader select wrong");
   AST_PROG_ENTRY: assert property (@(posedge i_clock) disable iff (i_rst)
      $rose(o_programming_mode) |-> $past(mode) == IDLE_WAIT) else $error("program mode without idle");
   AST_FETCH_LOADER: assert property (@(posedge i_clock) disable iff (i_rst)
      o_fetch_from_loader == o_programming_mode) else $error("fetch source wrong");
   AST_READ_ONLY: assert property (@(posedge i_clock) disable iff (i_rst)
      !$past(ctrl.flash_program_enable) |-> !o_flash_write_allowed) else $error("flash writable");
   AST_READ_MODE: assert property (@(posedge i_clock) disable iff (i_rst)
      rd_hit |=> o_hrdata[7] == $past(i_small_boot_mode))
      else $error("boot mode read wrong");
endmodule

// [sim/chip_boot_program_control_tb_top.sv]
// bench for chip boot and program control: register rows, reboot, programming entry
// assumes zero-wait ahb-lite slave and a 50 ns core clock
`timescale 1ns/1ps
module chip_boot_program_control_tb_top;
   import chip_boot_pkg::*;
   logic i_clock = 0, i_rst = 1, i_hsel = 0, i_hwrite = 0, i_hready = 1;
   logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, r;
   logic [1:0] i_htrans = 0;
   logic [2:0] i_hsize = 3'h2;
   logic i_idle_entered = 0, i_irq_wake = 0, i_small_boot_mode = 0;
   logic o_hreadyout, o_hresp, o_chip_reset, o_aux_ram_enable, o_fetch_from_loader;
   logic o_loader_in_small_area, o_flash_write_allowed, o_programming_mode;
   int n_mismatch = 0, comparisons = 0, cyc = 0, cnt;
   logic [15:0] rows [4] = '{16'h1010, 16'h0202, 16'h6000, 16'hF313};
   localparam logic [31:0] REG_ADDR = {22'h0, CHIP_CONTROL_OFFSET, 2'h0};
   chip_boot_program_control uut (
      .i_clock                (i_clock),
      .i_rst                  (i_rst),
      .i_hsel                 (i_hsel),
      .i_haddr                (i_haddr),
      .i_htrans               (i_htrans),
      .i_hwrite               (i_hwrite),
      .i_hsize                (i_hsize),
      .i_hwdata               (i_hwdata),
      .i_hready               (i_hready),
      .o_hrdata               (o_hrdata),
      .o_hreadyout            (o_hreadyout),
      .o_hresp                (o_hresp),
      .i_idle_entered         (i_idle_entered),
      .i_irq_wake             (i_irq_wake),
      .i_small_boot_mode      (i_small_boot_mode),
      .o_chip_reset           (o_chip_reset),
      .o_aux_ram_enable       (o_aux_ram_enable),
      .o_fetch_from_loader    (o_fetch_from_loader),
      .o_loader_in_small_area (o_loader_in_small_area),
      .o_flash_write_allowed  (o_flash_write_allowed),
      .o_programming_mode     (o_programming_mode)
   );
   initial forever #25 i_clock = ~i_clock;
   task automatic conclude;
      $display("counts: %0d compared, %0d bad", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      i_hsel <= 1'b1;
      i_haddr <= a;
      i_htrans <= HTRANS_NONSEQ;
      i_hwrite <= wr;
      do @(posedge i_clock); while (o_hreadyout !== 1'b1);
      i_htrans <= 2'h0;
      i_hwdata <= d;
      do @(posedge i_clock); while (o_hreadyout !== 1'b1);
      r = o_hrdata;
      chk("hresp", o_hresp, 0);
   endtask
   task automatic pulse(input logic idle);
      if (idle) i_idle_entered <= 1'b1;
      else i_irq_wake <= 1'b1;
      @(posedge i_clock);
      i_idle_entered <= 1'b0;
      i_irq_wake <= 1'b0;
      repeat (2) @(posedge i_clock);
   endtask
   initial begin
      repeat (5) @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      chk("aux after reset", o_aux_ram_enable, 0);
      xfer(0, REG_ADDR, 0);
      chk("reset value", r, {24'h0, CHIP_CONTROL_RESET});
      $display("reset test done");
      foreach (rows[i]) begin
         xfer(1, REG_ADDR, {24'h0, rows[i][15:8]});
         xfer(0, REG_ADDR, 0);
         chk("readback", r, {24'h0, rows[i][7:0]});
         chk("aux ram", o_aux_ram_enable, rows[i][4]);
         chk("loader area", o_loader_in_small_area, rows[i][1]);
         chk("no reboot", o_chip_reset, 0);
      end
      $display("row tests done");
      xfer(0, 32'h0000_0100, 0);
      chk("unmapped read", r, 0);
      i_small_boot_mode <= 1'b1;
      xfer(0, REG_ADDR, 0);
      chk("small boot flag", r[7], 1);
      i_small_boot_mode <= 1'b0;
      xfer(1, REG_ADDR, 32'h00);
      pulse(1);
      pulse(0);
      chk("disabled entry", o_programming_mode, 0);
      xfer(1, REG_ADDR, 32'h01);
      chk("write blocked", o_flash_write_allowed, 0);
      pulse(0);
      chk("wake alone", o_programming_mode, 0);
      pulse(1);
      pulse(0);
      chk("prog mode", o_programming_mode, 1);
      chk("fetch loader", o_fetch_from_loader, 1);
      chk("write allowed", o_flash_write_allowed, 1);
      xfer(1, REG_ADDR, 32'h00);
      repeat (2) @(posedge i_clock);
      chk("prog left", o_programming_mode, 0);
      $display("programming test done");
      xfer(1, REG_ADDR, 32'h01);
      xfer(1, REG_ADDR, 32'h81);
      cnt = 0;
      repeat (8) @(posedge i_clock) cnt += (o_chip_reset === 1'b1);
      chk("half reboot", cnt, 0);
      xfer(1, REG_ADDR, 32'h13);
      xfer(1, REG_ADDR, 32'h93);
      cnt = 0;
      repeat (10) @(posedge i_clock) cnt += (o_chip_reset === 1'b1);
      chk("reboot pulse", cnt, REBOOT_PULSE_CYCLES);
      xfer(0, REG_ADDR, 0);
      chk("after reboot", r, 0);
      chk("aux after reboot", o_aux_ram_enable, 0);
      $display("reboot test done");
      xfer(1, REG_ADDR, 32'h10);
      i_rst <= 1'b1;
      @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      chk("aux after mid reset", o_aux_ram_enable, 0);
      chk("ready after mid reset", o_hreadyout, 1);
      xfer(0, REG_ADDR, 0);
      chk("value after mid reset", r, {24'h0, CHIP_CONTROL_RESET});
      $display("mid reset test done");
      conclude();
   end
endmodule
